// >>> core/fscs_regs.svh
// Constants for the fail-safe and cyclic-sense control block
`ifndef FSCS_REGS_SVH
`define FSCS_REGS_SVH

`define FSCS_CLK_HZ          100000000
`define FSCS_FS_MIN_MS       100
`define FSCS_TSD_DELAY_MS    1000
`define FSCS_WAKE_FILT_US    16
`define FSCS_LP_DIV          100
`define FSCS_LP_TICK_HZ      (`FSCS_CLK_HZ / `FSCS_LP_DIV)
`define FSCS_FS_MIN_TICKS    ((`FSCS_FS_MIN_MS * `FSCS_LP_TICK_HZ) / 1000)
`define FSCS_TSD_TICKS       ((`FSCS_TSD_DELAY_MS * `FSCS_LP_TICK_HZ) / 1000)
`define FSCS_WAKE_FILT_CYC   ((`FSCS_WAKE_FILT_US * `FSCS_CLK_HZ) / 1000000)
`define FSCS_UV_FS_COUNT     4
`define FSCS_DEVSTAT_FS      2'h1
`define FSCS_WDFAIL_ONE      2'h1
`define FSCS_WDFAIL_TWO      2'h2
`define FSCS_TIMER_W         24

`endif

// >>> core/fscs_pkg.sv
// Types shared by the fail-safe and cyclic-sense control block
`default_nettype none
package fscs_pkg;

  typedef enum logic [2:0] {
    FSCS_MODE_INIT    = 3'b000,
    FSCS_MODE_NORMAL  = 3'b001,
    FSCS_MODE_STOP    = 3'b010,
    FSCS_MODE_SLEEP   = 3'b011,
    FSCS_MODE_RESTART = 3'b100,
    FSCS_MODE_FAILSAFE= 3'b101
  } fscs_mode_t;

  typedef struct packed {
    logic       failure;
    logic [1:0] device_mode_status;
    logic       thermal_shutdown_event;
    logic [1:0] watchdog_fail_field;
    logic       main_undervoltage_flag;
    logic       repeated_undervoltage_flag;
    logic       main_overvoltage_flag;
    logic       main_short_flag;
  } fscs_status_t;

  typedef struct packed {
    logic [23:0] period;
    logic [23:0] on_time;
    logic        start;
  } fscs_timer_cfg_t;

endpackage
`default_nettype wire

// >>> core/fscs_cyc_timer.sv
// Cyclic sense timer: period/on-time counter with error check
`include "fscs_regs.svh"
`default_nettype none
module fscs_cyc_timer (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire fscs_pkg::fscs_timer_cfg_t i_cfg,
  input  wire logic                     i_stop,
  output logic                          o_on,
  output logic                          o_on_end,
  output logic                          o_cfg_err
);
  logic [`FSCS_TIMER_W-1:0] cnt_q;
  logic                     run_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (i_stop) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (i_cfg.start) begin
      cnt_q <= '0;
      run_q <= (i_cfg.on_time != '0);
    end else if (run_q) begin
      if (cnt_q + 24'h1 >= i_cfg.period) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 24'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_on      <= 1'b0;
      o_on_end  <= 1'b0;
      o_cfg_err <= 1'b0;
    end else begin
      o_on      <= run_q && (cnt_q < i_cfg.on_time);
      o_on_end  <= run_q && (cnt_q + 24'h1 == i_cfg.on_time);
      o_cfg_err <= i_cfg.start && (i_cfg.on_time > i_cfg.period);
    end
  end
endmodule
`default_nettype wire

// >>> core/fscs_core.sv
// Fail-safe entry/exit, failure status, development mode and cyclic sense wake
`include "fscs_regs.svh"
`default_nettype none
// Summary of operation
// - Thermal shutdown or supply short enters fail-safe
// - Overvoltage enters fail-safe if enabled, parity zero
// - Watchdog failures: first or second per config
// - Four undervoltages with battery good enter fail-safe
// - Entry enables default wakes, clears wake flags, drivers off
// - Measurement-configured wake pins stay measurement
// - Stay minimum filter time; stored wakes restart
// - Thermal cause restarts after one second
// - Fail outputs activate, stay active after exit
// - Fail-safe: static wake, cyclic/HS/supplies off
// - Record failure flag and mode status 01
// - Set reason flags per failure cause
// - Development mode stops watchdog effects, defaults on in init mode
// - Latch development mode on init exit, pin low
// - Development mode kept until power-on reset
// - Cyclic wake edge: interrupt or wake device
// - Timer starts when on-time written
// - Switch held at chosen idle level before start
// - On-time above period flags command error
// - First sample reference; later change wakes
// - Filter after on-time; stable differing level wakes
// - Level status updated only in normal/stop
// - Switch fault disables switch; timer keeps running
module fscs_core (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  input  wire fscs_pkg::fscs_mode_t      i_mode,
  input  wire logic                      i_tsd,
  input  wire logic                      i_main_short,
  input  wire logic                      i_main_ov,
  input  wire logic                      i_main_uv,
  input  wire logic                      i_batt_ok,
  input  wire logic                      i_watchdog_fail_field,
  input  wire logic                      i_ov_rst_en,
  input  wire logic                      i_cfg_parity,
  input  wire logic                      i_cfg_select,
  input  wire logic                      i_wake_meas_sel,
  input  wire logic                      i_init_exit_spi,
  input  wire logic                      i_test_entry_pin,
  input  wire logic                      i_test_timeout,
  input  wire logic                      i_status_clr,
  input  wire logic [2:0]                i_wake_input,
  input  wire logic                      i_can_wake,
  input  wire fscs_pkg::fscs_timer_cfg_t i_timer_cfg,
  input  wire logic                      i_hs_idle_high,
  input  wire logic                      i_hs_fault,
  input  wire logic                      i_hs_map,
  output logic                           o_failsafe,
  output logic                           o_restart_req,
  output logic                           o_fail_outputs,
  output logic                           o_supplies_on,
  output logic                           o_dev_mode,
  output logic                           o_wd_run,
  output logic                           o_default_on,
  output logic [2:0]                     o_wake_enable,
  output logic                           o_static_sense,
  output logic                           o_high_side_switch,
  output logic                           o_int_n,
  output logic                           o_wake_req,
  output logic [2:0]                     o_wake_flags,
  output logic [2:0]                     o_wake_level_status,
  output logic                           o_cmd_err,
  output fscs_pkg::fscs_status_t         o_status
);
  localparam int unsigned FS_TICKS   = `FSCS_FS_MIN_TICKS;
  localparam int unsigned TSD_TICKS  = `FSCS_TSD_TICKS;
  localparam int unsigned FILT_CYC   = `FSCS_WAKE_FILT_CYC;

  // Pin synchronisers
  logic [2:0] wk_s1_q, wk_s2_q;
  logic       tp_s1_q, tp_s2_q, cw_s1_q, cw_s2_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wk_s1_q <= 3'h0;
      wk_s2_q <= 3'h0;
      tp_s1_q <= 1'b0;
      tp_s2_q <= 1'b0;
      cw_s1_q <= 1'b0;
      cw_s2_q <= 1'b0;
    end else begin
      wk_s1_q <= i_wake_input;
      wk_s2_q <= wk_s1_q;
      tp_s1_q <= i_test_entry_pin;
      tp_s2_q <= tp_s1_q;
      cw_s1_q <= i_can_wake;
      cw_s2_q <= cw_s1_q;
    end
  end

  // Low-power oscillator tick
  logic [6:0] lp_div_q;
  logic       lp_tick;
  assign lp_tick = (lp_div_q == 7'(`FSCS_LP_DIV - 1));
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lp_div_q <= 7'h0;
    end else begin
      lp_div_q <= lp_tick ? 7'h0 : lp_div_q + 7'h1;
    end
  end

  // Development mode latch
  logic dev_q, tp_high_long_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dev_q          <= 1'b0;
      tp_high_long_q <= 1'b0;
    end else begin
      if (i_mode == fscs_pkg::FSCS_MODE_INIT && tp_s2_q && i_test_timeout) begin
        tp_high_long_q <= 1'b1;
      end
      if (i_mode == fscs_pkg::FSCS_MODE_INIT && i_init_exit_spi && !tp_s2_q && !tp_high_long_q) begin
        dev_q <= 1'b1;
      end
    end
  end

  // Failure causes
  logic       wd_cnt_q;
  logic [2:0] uv_cnt_q;
  logic       uv_prev_q;
  logic       wd_trip, ov_trip, uv_trip, fs_entry;
  logic       fs_q;
  logic       wd_ev;
  assign wd_ev   = i_watchdog_fail_field && !dev_q;
  assign wd_trip = wd_ev && (i_cfg_select || wd_cnt_q);
  assign ov_trip = i_main_ov && i_ov_rst_en && !i_cfg_parity;
  assign uv_trip = i_main_uv && !uv_prev_q && i_batt_ok &&
                   (uv_cnt_q == 3'(`FSCS_UV_FS_COUNT - 1));
  assign fs_entry = !fs_q && (i_tsd || i_main_short || ov_trip || wd_trip || uv_trip);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_cnt_q  <= 1'b0;
      uv_cnt_q  <= 3'h0;
      uv_prev_q <= 1'b0;
    end else begin
      uv_prev_q <= i_main_uv;
      if (fs_entry) begin
        wd_cnt_q <= 1'b0;
        uv_cnt_q <= 3'h0;
      end else begin
        if (wd_ev) begin
          wd_cnt_q <= 1'b1;
        end
        if (!i_batt_ok) begin
          uv_cnt_q <= 3'h0;
        end else if (i_main_uv && !uv_prev_q) begin
          uv_cnt_q <= uv_cnt_q + 3'h1;
        end
      end
    end
  end

  // Fail-safe state, filter counter and wake store
  logic [19:0] fs_cnt_q;
  logic        tsd_cause_q, wake_store_q, fo_q;
  logic        fs_wake, filt_done, tsd_done;
  logic [2:0]  wk_ref_q;
  // Wake pins in measurement use are masked out before the change test
  assign fs_wake   = cw_s2_q || (|((wk_s2_q ^ wk_ref_q) & {1'b1, {2{!i_wake_meas_sel}}}));
  assign filt_done = (fs_cnt_q >= 20'(FS_TICKS));
  assign tsd_done  = (fs_cnt_q >= 20'(TSD_TICKS));
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fs_q          <= 1'b0;
      fs_cnt_q      <= 20'h0;
      tsd_cause_q   <= 1'b0;
      wake_store_q  <= 1'b0;
      o_restart_req <= 1'b0;
      wk_ref_q      <= 3'h0;
    end else begin
      o_restart_req <= 1'b0;
      if (fs_entry) begin
        fs_q         <= 1'b1;
        fs_cnt_q     <= 20'h0;
        tsd_cause_q  <= i_tsd;
        wake_store_q <= 1'b0;
        wk_ref_q     <= wk_s2_q;
      end else if (fs_q) begin
        if (lp_tick && !tsd_done) begin
          fs_cnt_q <= fs_cnt_q + 20'h1;
        end
        if (fs_wake) begin
          wake_store_q <= 1'b1;
        end
        if ((filt_done && (wake_store_q || fs_wake)) || (tsd_cause_q && tsd_done)) begin
          fs_q          <= 1'b0;
          o_restart_req <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fo_q <= 1'b0;
    end else if (fs_entry) begin
      fo_q <= 1'b1;
    end
  end

  // Failure status capture
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status <= '0;
    end else if (fs_entry) begin
      o_status.failure            <= 1'b1;
      o_status.device_mode_status <= `FSCS_DEVSTAT_FS;
      if (i_tsd) begin
        o_status.thermal_shutdown_event <= 1'b1;
      end
      if (wd_trip) begin
        o_status.watchdog_fail_field <= wd_cnt_q ? `FSCS_WDFAIL_TWO : `FSCS_WDFAIL_ONE;
      end
      if (i_main_short) begin
        o_status.main_undervoltage_flag <= 1'b1;
        o_status.main_short_flag        <= 1'b1;
      end
      if (uv_trip) begin
        o_status.main_undervoltage_flag     <= 1'b1;
        o_status.repeated_undervoltage_flag <= 1'b1;
      end
      if (ov_trip) begin
        o_status.main_overvoltage_flag <= 1'b1;
      end
    end else if (i_status_clr) begin
      o_status <= '0;
    end
  end

  // Cyclic sense
  logic cs_on, cs_end, cs_err;
  fscs_cyc_timer u_timer (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_cfg     (i_timer_cfg),
    .i_stop    (fs_q || fs_entry),
    .o_on      (cs_on),
    .o_on_end  (cs_end),
    .o_cfg_err (cs_err)
  );

  logic [10:0] filt_cnt_q;
  logic        filt_act_q, cs_first_q;
  logic [2:0]  filt_lvl_q, prev_lvl_q;
  logic        lp_mode, filt_fin;
  assign lp_mode  = (i_mode == fscs_pkg::FSCS_MODE_NORMAL) || (i_mode == fscs_pkg::FSCS_MODE_STOP);
  assign filt_fin = filt_act_q && (filt_cnt_q == 11'(FILT_CYC - 1));
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      filt_cnt_q   <= 11'h0;
      filt_act_q   <= 1'b0;
      filt_lvl_q   <= 3'h0;
      prev_lvl_q   <= 3'h0;
      cs_first_q   <= 1'b1;
      o_wake_flags <= 3'h0;
      o_int_n      <= 1'b1;
      o_wake_req   <= 1'b0;
      o_wake_level_status <= 3'h0;
    end else begin
      o_wake_req <= 1'b0;
      // Clear ahead of the filter so a wake in the same cycle wins
      if (i_status_clr) begin
        o_int_n <= 1'b1;
      end
      if (i_timer_cfg.start || fs_q) begin
        cs_first_q <= 1'b1;
        filt_act_q <= 1'b0;
      end else if (cs_end) begin
        filt_act_q <= 1'b1;
        filt_cnt_q <= 11'h0;
        filt_lvl_q <= wk_s2_q;
      end else if (filt_act_q) begin
        filt_cnt_q <= filt_cnt_q + 11'h1;
        if (wk_s2_q != filt_lvl_q) begin
          filt_act_q <= 1'b0;
        end else if (filt_fin) begin
          filt_act_q <= 1'b0;
          prev_lvl_q <= filt_lvl_q;
          cs_first_q <= 1'b0;
          if (lp_mode) begin
            o_wake_level_status <= filt_lvl_q;
          end
          if (!cs_first_q && (filt_lvl_q != prev_lvl_q)) begin
            o_wake_flags <= o_wake_flags | (filt_lvl_q ^ prev_lvl_q);
            if (lp_mode) begin
              o_int_n <= 1'b0;
            end else begin
              o_wake_req <= 1'b1;
            end
          end
        end
      end
      if (fs_entry) begin
        o_wake_flags <= 3'h0;
      end
    end
  end

  // Outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_failsafe         <= 1'b0;
      o_fail_outputs     <= 1'b0;
      o_supplies_on      <= 1'b0;
      o_dev_mode         <= 1'b0;
      o_wd_run           <= 1'b0;
      o_default_on       <= 1'b0;
      o_wake_enable      <= 3'h0;
      o_static_sense     <= 1'b0;
      o_high_side_switch <= 1'b0;
      o_cmd_err          <= 1'b0;
    end else begin
      o_failsafe     <= fs_q;
      o_fail_outputs <= fo_q;
      o_supplies_on  <= !fs_q;
      o_dev_mode     <= dev_q;
      o_wd_run       <= !dev_q && !fs_q;
      o_default_on   <= dev_q && (i_mode == fscs_pkg::FSCS_MODE_INIT);
      o_wake_enable  <= fs_q ? {1'b1, {2{!i_wake_meas_sel}}} : 3'h0;
      o_static_sense <= fs_q;
      if (fs_q || i_hs_fault || !i_hs_map) begin
        o_high_side_switch <= 1'b0;
      end else begin
        o_high_side_switch <= cs_on ? !i_hs_idle_high : i_hs_idle_high;
      end
      if (cs_err) begin
        o_cmd_err <= 1'b1;
      end else if (i_status_clr) begin
        o_cmd_err <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/fscs_core_properties.sv
// Checker for the fail-safe and cyclic-sense control block
`include "fscs_regs.svh"
`default_nettype none
module fscs_core_properties (
  input wire logic                      i_clk,
  input wire logic                      i_resetn,
  input wire logic                      i_tsd,
  input wire logic                      i_main_short,
  input wire logic                      i_main_ov,
  input wire logic                      i_ov_rst_en,
  input wire logic                      i_cfg_parity,
  input wire logic                      i_wake_meas_sel,
  input wire fscs_pkg::fscs_timer_cfg_t i_timer_cfg,
  input wire logic                      o_failsafe,
  input wire logic                      o_restart_req,
  input wire logic                      o_fail_outputs,
  input wire logic                      o_supplies_on,
  input wire logic                      o_high_side_switch,
  input wire logic                      o_static_sense,
  input wire logic [2:0]                o_wake_enable,
  input wire logic                      o_dev_mode,
  input wire logic                      o_wd_run,
  input wire logic                      o_cmd_err,
  input wire logic [2:0]                o_wake_flags,
  input wire fscs_pkg::fscs_status_t    o_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_tsd; !o_failsafe && i_tsd |-> ##2 o_failsafe; endproperty
  a_tsd: assert property (p_tsd) else $error("no fail-safe after thermal event");
  property p_short; !o_failsafe && i_main_short |-> ##2 o_failsafe; endproperty
  a_short: assert property (p_short) else $error("no fail-safe after supply short");
  property p_ov; !o_failsafe && i_main_ov && i_ov_rst_en && !i_cfg_parity |-> ##2 o_failsafe; endproperty
  a_ov: assert property (p_ov) else $error("no fail-safe after overvoltage");
  property p_wake_en; o_failsafe |-> o_wake_enable == {1'b1, {2{!i_wake_meas_sel}}}; endproperty
  a_wake_en: assert property (p_wake_en) else $error("wrong wake sources in fail-safe");
  property p_quiet; o_failsafe |-> o_static_sense && !o_supplies_on && !o_high_side_switch; endproperty
  a_quiet: assert property (p_quiet) else $error("supplies or switch on in fail-safe");
  property p_fo; o_fail_outputs |=> o_fail_outputs; endproperty
  a_fo: assert property (p_fo) else $error("fail outputs dropped");
  property p_restart; o_restart_req |-> o_failsafe ##1 !o_failsafe; endproperty
  a_restart: assert property (p_restart) else $error("restart request without fail-safe exit");
  property p_stat; $rose(o_failsafe) |-> o_status.failure && o_status.device_mode_status == `FSCS_DEVSTAT_FS; endproperty
  a_stat: assert property (p_stat) else $error("fail-safe not recorded");
  property p_dev_keep; o_dev_mode |=> o_dev_mode; endproperty
  a_dev_keep: assert property (p_dev_keep) else $error("development mode lost");
  property p_dev_wd; o_dev_mode |-> !o_wd_run; endproperty
  a_dev_wd: assert property (p_dev_wd) else $error("watchdog runs in development mode");
  property p_cmd; i_timer_cfg.start && i_timer_cfg.on_time > i_timer_cfg.period |-> ##2 o_cmd_err; endproperty
  a_cmd: assert property (p_cmd) else $error("bad on-time not flagged");

  c_fs: cover property ($rose(o_failsafe));
  c_dev: cover property ($rose(o_dev_mode));
  c_wake: cover property (o_wake_flags != 3'h0);
endmodule

bind fscs_core fscs_core_properties chk_u (
  .i_clk, .i_resetn, .i_tsd, .i_main_short, .i_main_ov, .i_ov_rst_en, .i_cfg_parity,
  .i_wake_meas_sel, .i_timer_cfg, .o_failsafe, .o_restart_req, .o_fail_outputs, .o_supplies_on,
  .o_high_side_switch, .o_static_sense, .o_wake_enable, .o_dev_mode, .o_wd_run,
  .o_cmd_err, .o_wake_flags, .o_status
);
`default_nettype wire

// >>> testbench/fscs_host_model.sv
// Host microcontroller model: test pin, init exit, status clear, timer setup
`default_nettype none
module fscs_host_model (
  input  wire logic                 i_clk,
  output logic                      o_test_entry_pin,
  output logic                      o_init_exit_spi,
  output logic                      o_status_clr,
  output fscs_pkg::fscs_timer_cfg_t o_timer_cfg
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_test_entry_pin = 1'b1;
    o_init_exit_spi = 1'b0;
    o_status_clr = 1'b0;
    o_timer_cfg = '0;
  end

  task automatic leave_init(input logic dev);
    @(negedge i_clk);
    o_test_entry_pin = !dev;
    repeat (4) @(negedge i_clk);
    o_init_exit_spi = 1'b1;
    @(negedge i_clk);
    o_init_exit_spi = 1'b0;
    repeat (4) @(negedge i_clk);
    o_test_entry_pin = 1'b1;
  endtask

  task automatic clear_status();
    @(negedge i_clk);
    o_status_clr = 1'b1;
    @(negedge i_clk);
    o_status_clr = 1'b0;
  endtask

  task automatic start_timer(input logic [23:0] per, input logic [23:0] on);
    @(negedge i_clk);
    o_timer_cfg.period = per;
    o_timer_cfg.on_time = on;
    @(negedge i_clk);
    o_timer_cfg.start = 1'b1;
    @(negedge i_clk);
    o_timer_cfg.start = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/fscs_core_tb.sv
// Self-checking bench for the fail-safe and cyclic-sense control block
`include "fscs_regs.svh"
`default_nettype none
module fscs_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_resetn, i_tsd, i_main_short, i_main_ov, i_main_uv, i_batt_ok, i_watchdog_fail_field;
  logic i_ov_rst_en, i_cfg_parity, i_cfg_select, i_wake_meas_sel, i_test_timeout;
  logic i_test_entry_pin, i_init_exit_spi, i_status_clr, i_can_wake;
  logic i_hs_idle_high, i_hs_fault, i_hs_map;
  logic [2:0] i_wake_input, o_wake_enable, o_wake_flags, o_wake_level_status;
  logic o_failsafe, o_restart_req, o_fail_outputs, o_supplies_on, o_dev_mode, o_wd_run;
  logic o_default_on, o_static_sense, o_high_side_switch, o_int_n, o_wake_req, o_cmd_err;
  fscs_pkg::fscs_mode_t      i_mode;
  fscs_pkg::fscs_timer_cfg_t i_timer_cfg;
  fscs_pkg::fscs_status_t    o_status;
  fscs_pkg::fscs_status_t    e;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  fscs_core dut_u (
    .i_clk, .i_resetn, .i_mode, .i_tsd, .i_main_short, .i_main_ov, .i_main_uv, .i_batt_ok,
    .i_watchdog_fail_field, .i_ov_rst_en, .i_cfg_parity, .i_cfg_select, .i_wake_meas_sel, .i_init_exit_spi,
    .i_test_entry_pin, .i_test_timeout, .i_status_clr, .i_wake_input, .i_can_wake, .i_timer_cfg,
    .i_hs_idle_high, .i_hs_fault, .i_hs_map, .o_failsafe, .o_restart_req, .o_fail_outputs,
    .o_supplies_on, .o_dev_mode, .o_wd_run, .o_default_on, .o_wake_enable, .o_static_sense,
    .o_high_side_switch, .o_int_n, .o_wake_req, .o_wake_flags, .o_wake_level_status, .o_cmd_err,
    .o_status
  );

  fscs_host_model host_u (
    .i_clk, .o_test_entry_pin(i_test_entry_pin), .o_init_exit_spi(i_init_exit_spi),
    .o_status_clr(i_status_clr), .o_timer_cfg(i_timer_cfg)
  );

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (4) @(negedge i_clk);
  endtask

  task automatic do_reset(input logic dev);
    i_resetn = 1'b0;
    {i_tsd, i_main_short, i_main_ov, i_main_uv, i_watchdog_fail_field} = '0;
    i_mode = fscs_pkg::FSCS_MODE_INIT;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    host_u.leave_init(dev);
    i_mode = fscs_pkg::FSCS_MODE_NORMAL;
  endtask

  // One failure pulse: 0 thermal, 1 short, 2 overvoltage, 5 undervoltage, else watchdog
  task automatic cause(input int k);
    @(negedge i_clk);
    case (k)
      0: i_tsd = 1'b1;
      1: i_main_short = 1'b1;
      2: i_main_ov = 1'b1;
      5: i_main_uv = 1'b1;
      default: i_watchdog_fail_field = 1'b1;
    endcase
    @(negedge i_clk);
    {i_tsd, i_main_short, i_main_ov, i_main_uv, i_watchdog_fail_field} = '0;
  endtask

  initial begin
    {i_batt_ok, i_ov_rst_en, i_hs_map} = 3'h7;
    {i_cfg_parity, i_cfg_select, i_wake_meas_sel, i_test_timeout, i_can_wake} = '0;
    {i_hs_idle_high, i_hs_fault} = '0;
    i_wake_input = 3'h0;
    for (int k = 0; k < 7; k++) begin
      do_reset(k == 6);
      i_cfg_select = (k == 3);
      i_cfg_parity = (k == 2);
      i_wake_meas_sel = (k == 1);
      if (k == 6) begin
        chk(o_dev_mode, 1'b1);
        chk({o_wd_run, o_default_on}, 2'h1);
      end
      if (k == 2) begin
        cause(2);
        settle();
        chk(o_failsafe, 1'b0);
        i_cfg_parity = 1'b0;
      end
      repeat (k == 4 ? 1 : k == 5 ? 3 : k == 6 ? 2 : 0) cause(k);
      settle();
      chk(o_failsafe, 1'b0);
      cause(k == 6 ? 0 : k);
      settle();
      chk({o_failsafe, o_fail_outputs, o_supplies_on}, 3'h6);
      chk(o_wake_enable, k == 1 ? 3'h4 : 3'h7);
      e = '0;
      e.failure = 1'b1;
      e.device_mode_status = `FSCS_DEVSTAT_FS;
      e.thermal_shutdown_event = (k == 0 || k == 6);
      e.main_undervoltage_flag = (k == 1 || k == 5);
      e.main_short_flag = (k == 1);
      e.main_overvoltage_flag = (k == 2);
      e.repeated_undervoltage_flag = (k == 5);
      e.watchdog_fail_field = k == 3 ? `FSCS_WDFAIL_ONE : k == 4 ? `FSCS_WDFAIL_TWO : 2'h0;
      chk(o_status, e);
      chk(o_dev_mode, k == 6);
    end
    do_reset(1'b0);
    i_hs_idle_high = 1'b1;
    settle();
    chk(o_high_side_switch, 1'b1);
    host_u.start_timer(24'h000fa0, 24'h0003e8);
    repeat (9000) @(negedge i_clk);
    chk(o_wake_flags, 3'h0);
    i_wake_input = 3'h1;
    repeat (9000) @(negedge i_clk);
    chk({o_wake_flags, o_wake_level_status, o_int_n}, 7'h12);
    host_u.clear_status();
    settle();
    chk(o_int_n, 1'b1);
    i_mode = fscs_pkg::FSCS_MODE_SLEEP;
    i_wake_input = 3'h3;
    n = 0;
    while (o_wake_req !== 1'b1 && n < 9000) begin
      @(negedge i_clk);
      n++;
    end
    // Wake flags are sticky: the bit from the normal-mode wake is still set
    chk({o_wake_req, o_wake_flags, o_wake_level_status}, 7'h59);
    host_u.start_timer(24'h000010, 24'h000020);
    settle();
    chk(o_cmd_err, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
